// File: core/interrupt_vector_priority_map.v
// Interrupt source priority resolution and vector fetch for the CPU core.
`timescale 1ns/1ns
`include "int_vector_consts.vh"
// Notes on behaviour
// - All vectors and the start vector live in word window ff80h to ffffh.
// - Each vector word holds the 16-bit handler address the CPU loads next.
// - Every reset cause uses vector fffeh at top priority 63.
// - System nonmaskable events use vector fffch at priority 62.
// - First timer: compare-0 at fff8h/60; others share fff6h/59.
// - Second timer: compare-0 at fff4h/58; others share fff2h/57.
// - Real-time counter fff0h/56; interval-mode watchdog ffeeh/55.
// - First serial interface uses vector ffech at priority 54.
// - Second serial interface uses vector ffeah at priority 53.
// - Converter uses vector ffe8h at priority 52.
// - Port 1 uses ffe6h/51, port 2 uses ffe4h/50.
module interrupt_vector_priority_map
(
	input wire clock_i, // System clock, 125 MHz.
	input wire rst_i, // Synchronous reset, active high.
	input wire [8:0] reset_cause_i, // Reset causes, one bit each.
	input wire [5:0] sys_nmi_i, // System nonmaskable event flags.
	input wire external_nmi_flag_i, // External nonmaskable request.
	input wire oscillator_fault_flag_i, // Oscillator fault flag.
	input wire timer_a_cc0_i, // First timer compare-0 flag.
	input wire [2:0] timer_a_shared_i, // First timer compare-1, compare-2, overflow.
	input wire timer_b_cc0_i, // Second timer compare-0 flag.
	input wire [2:0] timer_b_shared_i, // Second timer compare-1, compare-2, overflow.
	input wire rt_counter_flag_i, // Real-time counter flag.
	input wire watchdog_flag_i, // Watchdog flag.
	input wire watchdog_interval_mode_i, // High when watchdog runs in interval mode.
	input wire serial_a_spi_mode_i, // High when first serial interface is in SPI mode.
	input wire [3:0] serial_a_flags_i, // Tx-complete, start, receive, transmit.
	input wire serial_b_i2c_mode_i, // High when second serial interface is in I2C mode.
	input wire [13:0] serial_b_flags_i, // Bus flags; bits 1:0 receive/transmit in SPI.
	input wire [5:0] converter_flags_i, // Converter event flags.
	input wire [7:0] port1_flags_i, // Port 1 pin flags 0 to 7.
	input wire [6:0] port2_flags_i, // Port 2 pin flags 0 to 6.
	input wire global_int_enable_i, // CPU global interrupt enable.
	input wire ack_i, // CPU accepts the offered vector, one-cycle pulse.
	input wire vec_wr_i, // Write strobe for a vector word.
	input wire [15:0] vec_wr_addr_i, // Word address of the vector to write.
	input wire [15:0] vec_wr_data_i, // Handler address to store.
	output reg irq_o, // A request is offered to the CPU.
	output reg [5:0] irq_priority_o, // Priority of the offered request.
	output reg [15:0] irq_vector_addr_o, // Vector address of the offered request.
	output reg [15:0] handler_addr_o, // Handler address read from the vector.
	output reg handler_valid_o, // Handler address valid, one-cycle pulse.
	output reg nmi_status_o // A system or user nonmaskable class is pending.
);
	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function [5:0] vec_index;
		input [15:0] addr;
		begin
			vec_index = addr[6:1];
		end
	endfunction

	function in_window;
		input [15:0] addr;
		begin
			in_window = (addr >= `VEC_WINDOW_LO) && (addr <= `VEC_WINDOW_HI);
		end
	endfunction

	// ****************************************************************
	// Source grouping
	// ****************************************************************
	wire [`SRC_COUNT-1:0] pending;
	wire [3:0] serial_a_live;
	wire [13:0] serial_b_live;
	assign serial_a_live = serial_a_spi_mode_i ? {2'h0, serial_a_flags_i[1:0]} :
		serial_a_flags_i;
	assign serial_b_live = serial_b_i2c_mode_i ? serial_b_flags_i :
		{12'h000, serial_b_flags_i[1:0]};
	assign pending[13] = |reset_cause_i;
	assign pending[12] = |sys_nmi_i;
	assign pending[11] = external_nmi_flag_i | oscillator_fault_flag_i;
	assign pending[10] = timer_a_cc0_i & global_int_enable_i;
	assign pending[9] = (|timer_a_shared_i) & global_int_enable_i;
	assign pending[8] = timer_b_cc0_i & global_int_enable_i;
	assign pending[7] = (|timer_b_shared_i) & global_int_enable_i;
	assign pending[6] = rt_counter_flag_i & global_int_enable_i;
	assign pending[5] = watchdog_flag_i & watchdog_interval_mode_i &
		global_int_enable_i;
	assign pending[4] = (|serial_a_live) & global_int_enable_i;
	assign pending[3] = (|serial_b_live) & global_int_enable_i;
	assign pending[2] = (|converter_flags_i) & global_int_enable_i;
	assign pending[1] = (|port1_flags_i) & global_int_enable_i;
	assign pending[0] = (|port2_flags_i) & global_int_enable_i;

	// ****************************************************************
	// Priority resolution
	// ****************************************************************
	reg next_irq;
	reg [5:0] next_priority;
	reg [15:0] next_vector;
	always @*
	begin
		next_irq = 1'b1;
		next_priority = `PRI_PORT2;
		next_vector = `VEC_PORT2;
		if (pending[13])
		begin
			next_priority = `PRI_RESET;
			next_vector = `VEC_RESET;
		end
		else if (pending[12])
		begin
			next_priority = `PRI_SYS_NMI;
			next_vector = `VEC_SYS_NMI;
		end
		else if (pending[11])
		begin
			next_priority = `PRI_USER_NMI;
			next_vector = `VEC_USER_NMI;
		end
		else if (pending[10])
		begin
			next_priority = `PRI_TIMER_A_CC0;
			next_vector = `VEC_TIMER_A_CC0;
		end
		else if (pending[9])
		begin
			next_priority = `PRI_TIMER_A_SHARED;
			next_vector = `VEC_TIMER_A_SHARED;
		end
		else if (pending[8])
		begin
			next_priority = `PRI_TIMER_B_CC0;
			next_vector = `VEC_TIMER_B_CC0;
		end
		else if (pending[7])
		begin
			next_priority = `PRI_TIMER_B_SHARED;
			next_vector = `VEC_TIMER_B_SHARED;
		end
		else if (pending[6])
		begin
			next_priority = `PRI_RT_COUNTER;
			next_vector = `VEC_RT_COUNTER;
		end
		else if (pending[5])
		begin
			next_priority = `PRI_WATCHDOG;
			next_vector = `VEC_WATCHDOG;
		end
		else if (pending[4])
		begin
			next_priority = `PRI_SERIAL_A;
			next_vector = `VEC_SERIAL_A;
		end
		else if (pending[3])
		begin
			next_priority = `PRI_SERIAL_B;
			next_vector = `VEC_SERIAL_B;
		end
		else if (pending[2])
		begin
			next_priority = `PRI_CONVERTER;
			next_vector = `VEC_CONVERTER;
		end
		else if (pending[1])
		begin
			next_priority = `PRI_PORT1;
			next_vector = `VEC_PORT1;
		end
		else if (pending[0])
		begin
			next_priority = `PRI_PORT2;
			next_vector = `VEC_PORT2;
		end
		else
		begin
			next_irq = 1'b0;
		end
	end

	// ****************************************************************
	// Vector fetch sequence
	// ****************************************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_DONE = 2'h3;
	reg [1:0] state;
	reg [15:0] fetch_addr;
	wire [15:0] rd_data;
	wire table_wr;
	assign table_wr = vec_wr_i & in_window(vec_wr_addr_i);

	vector_table_mem u_table
	(
		.clock_i(clock_i),
		.wr_en_i(table_wr),
		.wr_index_i(vec_index(vec_wr_addr_i)),
		.wr_data_i(vec_wr_data_i),
		.rd_index_i(vec_index(fetch_addr)),
		.rd_data_o(rd_data)
	);

	// ****************************************************************
	// Fetch state sequencing
	// ****************************************************************
	reg [1:0] next_state;
	wire take;
	// An acknowledge is only honoured against an offer that is showing in idle.
	assign take = (state == ST_IDLE) & irq_o & ack_i;
	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (take)
				begin
					next_state = ST_READ;
				end
			end
			ST_READ:
			begin
				next_state = ST_WAIT;
			end
			ST_WAIT:
			begin
				next_state = ST_DONE;
			end
			ST_DONE:
			begin
				next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Offer registers
	// ****************************************************************
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			irq_o <= 1'b0;
			irq_priority_o <= `OUT_RESET_PRIORITY;
			irq_vector_addr_o <= `OUT_RESET_ADDR;
			fetch_addr <= `VEC_RESET;
		end
		else if (state == ST_IDLE)
		begin
			// A taken offer drops at once so the core cannot take it twice; the
			// fetch works from the address that the core saw, not the new winner.
			irq_o <= next_irq & ~take;
			irq_priority_o <= next_priority;
			irq_vector_addr_o <= next_vector;
			if (take)
			begin
				fetch_addr <= irq_vector_addr_o;
			end
		end
	end

	// ****************************************************************
	// Handler output
	// ****************************************************************
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			handler_addr_o <= `OUT_RESET_ADDR;
			handler_valid_o <= 1'b0;
		end
		else
		begin
			handler_valid_o <= (state == ST_WAIT);
			if (state == ST_WAIT)
			begin
				handler_addr_o <= rd_data;
			end
		end
	end

	// ****************************************************************
	// Status output
	// ****************************************************************
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			nmi_status_o <= 1'b0;
		end
		else
		begin
			nmi_status_o <= pending[12] | pending[11];
		end
	end
endmodule

// File: include/int_vector_consts.vh
// Vector addresses, priorities, table sizes and reset values of the interrupt vector map.
`ifndef INT_VECTOR_CONSTS_VH
`define INT_VECTOR_CONSTS_VH
`define VEC_WINDOW_LO 16'hff80
`define VEC_WINDOW_HI 16'hffff
`define VEC_RESET 16'hfffe
`define VEC_SYS_NMI 16'hfffc
`define VEC_USER_NMI 16'hfffa
`define VEC_TIMER_A_CC0 16'hfff8
`define VEC_TIMER_A_SHARED 16'hfff6
`define VEC_TIMER_B_CC0 16'hfff4
`define VEC_TIMER_B_SHARED 16'hfff2
`define VEC_RT_COUNTER 16'hfff0
`define VEC_WATCHDOG 16'hffee
`define VEC_SERIAL_A 16'hffec
`define VEC_SERIAL_B 16'hffea
`define VEC_CONVERTER 16'hffe8
`define VEC_PORT1 16'hffe6
`define VEC_PORT2 16'hffe4
`define PRI_RESET 6'h3f
`define PRI_SYS_NMI 6'h3e
`define PRI_USER_NMI 6'h3d
`define PRI_TIMER_A_CC0 6'h3c
`define PRI_TIMER_A_SHARED 6'h3b
`define PRI_TIMER_B_CC0 6'h3a
`define PRI_TIMER_B_SHARED 6'h39
`define PRI_RT_COUNTER 6'h38
`define PRI_WATCHDOG 6'h37
`define PRI_SERIAL_A 6'h36
`define PRI_SERIAL_B 6'h35
`define PRI_CONVERTER 6'h34
`define PRI_PORT1 6'h33
`define PRI_PORT2 6'h32
`define SRC_COUNT 14
`define VEC_TABLE_DEPTH 64
`define VEC_INDEX_BITS 6
`define OUT_RESET_PRIORITY 6'h00
`define OUT_RESET_ADDR 16'h0000
`endif

// File: core/vector_table_mem.v
// Vector word memory covering the top window of the address map.
`timescale 1ns/1ns
module vector_table_mem
(
	input wire clock_i, // System clock.
	input wire wr_en_i, // Write strobe for one vector word.
	input wire [5:0] wr_index_i, // Word index inside the window.
	input wire [15:0] wr_data_i, // Handler address to store.
	input wire [5:0] rd_index_i, // Word index to read.
	output reg [15:0] rd_data_o // Registered handler address.
);
	reg [15:0] mem [0:63];
	always @(posedge clock_i)
	begin
		if (wr_en_i)
		begin
			mem[wr_index_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_index_i];
	end
endmodule

// File: testbench/ivpm_chk.sv
// Assertion checker for the interrupt vector priority map.
`timescale 1ns/1ns
module ivpm_chk
(
	input clock_i, // System clock.
	input rst_i, // Reset.
	input [8:0] reset_cause_i, // Reset causes.
	input [5:0] sys_nmi_i, // System events.
	input external_nmi_flag_i, // User event.
	input oscillator_fault_flag_i, // User event.
	input global_int_enable_i, // Global enable.
	input ack_i, // Acceptance.
	input irq_o, // Offer.
	input [5:0] irq_priority_o, // Offer priority.
	input [15:0] irq_vector_addr_o, // Offer vector.
	input handler_valid_o, // Handler strobe.
	input nmi_status_o // Event status.
);
	wire rst_any = |reset_cause_i;
	wire sys_any = |sys_nmi_i;
	wire nmi_any = sys_any | external_nmi_flag_i | oscillator_fault_flag_i;
	wire take = irq_o & ack_i;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	property p_top; irq_o && $past(irq_o) && $past(rst_any) |-> irq_priority_o == 6'h3f; endproperty
	a_top: assert property (p_top) else $error("reset priority");
	property p_sys; irq_o && $past(irq_o) && $past(sys_any) && !$past(rst_any)
		|-> irq_vector_addr_o == 16'hfffc; endproperty
	a_sys: assert property (p_sys) else $error("system event vector");
	property p_pair; irq_o |-> irq_vector_addr_o == {9'h1ff, irq_priority_o, 1'b0}
		&& irq_priority_o >= 6'h32; endproperty
	a_pair: assert property (p_pair) else $error("vector pairing");
	property p_mask; irq_o && $past(irq_o) && !$past(global_int_enable_i)
		|-> irq_priority_o >= 6'h3d; endproperty
	a_mask: assert property (p_mask) else $error("masked offer");
	property p_drop; take |=> !irq_o; endproperty
	a_drop: assert property (p_drop) else $error("offer kept");
	property p_fetch; take |-> ##3 handler_valid_o; endproperty
	a_fetch: assert property (p_fetch) else $error("no handler");
	property p_cause; handler_valid_o |-> $past(take, 3) && !$past(handler_valid_o); endproperty
	a_cause: assert property (p_cause) else $error("stray handler");
	property p_nmi; !$past(rst_i) |-> nmi_status_o == $past(nmi_any); endproperty
	a_nmi: assert property (p_nmi) else $error("event status");
	c_take: cover property (take);
	c_low: cover property (irq_o && irq_priority_o == 6'h32);
	c_top: cover property (irq_o && irq_priority_o == 6'h3f);
endmodule
bind interrupt_vector_priority_map ivpm_chk i_ivpm_chk (.*);

// File: testbench/cpu_core_model.sv
// CPU core model that accepts offered requests after a chosen delay.
`timescale 1ns/1ns
module cpu_core_model
(
	input wire clock_i, // System clock.
	input wire rst_i, // Reset.
	input wire irq_i, // Offer from the map.
	input wire go_i, // Core may take requests.
	input wire [3:0] delay_i, // Wait before accepting.
	output reg ack_o // Acceptance pulse.
);
	reg [4:0] waited;
	always @(posedge clock_i)
	begin
		if (rst_i || !irq_i || !go_i || ack_o)
		begin
			ack_o <= 1'b0;
			waited <= 5'h00;
		end
		else if (waited >= delay_i)
			ack_o <= 1'b1;
		else
			waited <= waited + 5'h01;
	end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the interrupt vector priority map.
`timescale 1ns/1ns
module testbench;
	reg clock_i = 1'b0;
	reg rst_i = 1'b1;
	reg [65:0] src = 66'h0;
	reg [3:0] modes = 4'h0;
	reg [3:0] dly = 4'h0;
	reg go = 1'b0;
	reg vec_wr = 1'b0;
	reg [15:0] wa = 16'h0000;
	reg [15:0] wd = 16'h0000;
	reg [15:0] mem [0:63];
	reg [95:0] r;
	reg [15:0] exp_q [$];
	wire ack, irq, hv, nmi;
	wire [5:0] pri;
	wire [15:0] va, ha;
	integer seed = 95995;
	integer bad_count = 0;
	integer n_compared = 0;
	integer cycles = 0;
	integer i, p, e, k;
	always #4 clock_i = ~clock_i;
	interrupt_vector_priority_map i_interrupt_vector_priority_map
	(
		.clock_i(clock_i), .rst_i(rst_i), .reset_cause_i(src[65:57]), .sys_nmi_i(src[56:51]),
		.external_nmi_flag_i(src[50]), .oscillator_fault_flag_i(src[49]),
		.timer_a_cc0_i(src[48]), .timer_a_shared_i(src[47:45]), .timer_b_cc0_i(src[44]),
		.timer_b_shared_i(src[43:41]), .rt_counter_flag_i(src[40]), .watchdog_flag_i(src[39]),
		.watchdog_interval_mode_i(modes[2]), .serial_a_spi_mode_i(modes[1]),
		.serial_a_flags_i(src[38:35]), .serial_b_i2c_mode_i(modes[0]),
		.serial_b_flags_i(src[34:21]), .converter_flags_i(src[20:15]),
		.port1_flags_i(src[14:7]), .port2_flags_i(src[6:0]), .global_int_enable_i(modes[3]),
		.ack_i(ack), .vec_wr_i(vec_wr), .vec_wr_addr_i(wa), .vec_wr_data_i(wd),
		.irq_o(irq), .irq_priority_o(pri), .irq_vector_addr_o(va), .handler_addr_o(ha),
		.handler_valid_o(hv), .nmi_status_o(nmi)
	);
	cpu_core_model i_cpu_core_model
	(
		.clock_i(clock_i), .rst_i(rst_i), .irq_i(irq), .go_i(go), .delay_i(dly), .ack_o(ack)
	);
	function integer exp_pri(input [65:0] s, input [3:0] m);
	begin
		exp_pri = 0;
		if (|s[65:57]) exp_pri = 63;
		else if (|s[56:51]) exp_pri = 62;
		else if (|s[50:49]) exp_pri = 61;
		else if (m[3])
		begin
			if (s[48]) exp_pri = 60;
			else if (|s[47:45]) exp_pri = 59;
			else if (s[44]) exp_pri = 58;
			else if (|s[43:41]) exp_pri = 57;
			else if (s[40]) exp_pri = 56;
			else if (s[39] && m[2]) exp_pri = 55;
			else if (m[1] ? |s[36:35] : |s[38:35]) exp_pri = 54;
			else if (m[0] ? |s[34:21] : |s[22:21]) exp_pri = 53;
			else if (|s[20:15]) exp_pri = 52;
			else if (|s[14:7]) exp_pri = 51;
			else if (|s[6:0]) exp_pri = 50;
		end
	end
	endfunction
	task chk(input [15:0] seen, input [15:0] want);
	begin
		n_compared = n_compared + 1;
		if (seen !== want)
		begin
			bad_count = bad_count + 1;
			$display("Error %0t: seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task results;
	begin
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task wr(input [15:0] a, input [15:0] d);
	begin
		@(posedge clock_i);
		vec_wr <= 1'b1;
		wa <= a;
		wd <= d;
		@(posedge clock_i);
		vec_wr <= 1'b0;
	end
	endtask
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			bad_count = bad_count + 1;
			results;
		end
	end
	always @(negedge clock_i)
	begin
		if (!rst_i && hv !== 1'b0)
		begin
			if (exp_q.size() == 0)
				chk(hv, 1'b0);
			else
				chk(ha, exp_q.pop_front());
		end
	end
	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		@(negedge clock_i);
		chk({hv, irq}, 16'h0000);
		for (i = 0; i < 64; i = i + 1)
		begin
			mem[i] = $random(seed);
			wr(16'hff80 + 2 * i, mem[i]);
		end
		wr(16'hff7e, ~mem[63]);
		repeat (200)
		begin
			p = {$random(seed)} % 66;
			r = {$random(seed), $random(seed), $random(seed)};
			@(posedge clock_i);
			src <= (r[65:0] & ((66'h1 << p) - 66'h1)) | (66'h1 << p);
			modes <= $random(seed);
			dly <= $random(seed);
			repeat (2) @(posedge clock_i);
			@(negedge clock_i);
			e = exp_pri(src, modes);
			chk(irq, e != 0);
			chk(nmi, |src[56:49]);
			if (e != 0)
			begin
				chk(pri, e);
				chk(va, 16'hff80 + 2 * e);
				exp_q.push_back(mem[e]);
				@(posedge clock_i);
				go <= 1'b1;
				k = 0;
				while (exp_q.size() != 0 && k < 40)
				begin
					@(negedge clock_i);
					k = k + 1;
				end
				chk(k < 40, 1'b1);
				@(posedge clock_i);
				go <= 1'b0;
			end
		end
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk({nmi, hv, irq, pri}, 16'h0000);
		chk(va, 16'h0000);
		@(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		chk(irq, exp_pri(src, modes) != 0);
		chk(nmi, |src[56:49]);
		results;
	end
endmodule
